/* hw/mcfd_mcu_end.sv */
// Memory unit lockstep fault detection end
module mcfd_mcu_end (
    input wire logic ref_clk,
    input wire logic rst_n,
    mcfd_if.dev link,
    input wire logic init,
    input wire logic [mcfd_pkg::MB_DATA_W-1:0] mbDataInt,
    input wire logic [mcfd_pkg::CTL_W-1:0] mbCtlInt,
    input wire logic [mcfd_pkg::CHK_W-1:0] mbChkInt,
    input wire logic mbDrive,
    input wire logic [mcfd_pkg::ARR_AD_W-1:0] adInt,
    input wire logic adDrive,
    input wire logic rasIntN,
    input wire logic deIntN,
    input wire logic weIntN,
    input wire logic refreshInt,
    input wire logic busActive,
    input wire logic bufChkStrap,
    input wire logic swDisWr,
    input wire logic [mcfd_pkg::DIS_W-1:0] swDisVal,
    input wire logic flagClr,
    input wire logic eccErr,
    input wire logic rxValid,
    output logic isMaster,
    output logic [mcfd_pkg::DIS_W-1:0] disBits,
    output logic mbFrcFlag,
    output logic arrFrcFlag,
    output logic bufChkFlag,
    output logic eccRptPulse,
    output logic commitPulse
);
    typedef struct packed {
        mcfd_pkg::mcfd_mb_t mbOut;
        logic mbOe;
        logic [mcfd_pkg::ARR_AD_W-1:0] adOut;
        logic adOe;
        mcfd_pkg::mcfd_actl_t actlOut;
        logic actlOe;
        logic [mcfd_pkg::NUM_BUS-1:0] bus_select_enable;
        logic roleOe;
        mcfd_pkg::mcfd_pins_t s1;
        mcfd_pkg::mcfd_pins_t s2;
        logic roleS1;
        logic roleS2;
        logic mbDrv;
        logic adDrv;
        mcfd_pkg::mcfd_mb_t [mcfd_pkg::PIN_LAT-1:0] mbHist;
        logic [mcfd_pkg::PIN_LAT-1:0] mbDrvHist;
        logic [mcfd_pkg::PIN_LAT-1:0][mcfd_pkg::ARR_AD_W-1:0] adHist;
        logic [mcfd_pkg::PIN_LAT-1:0] adDrvHist;
        mcfd_pkg::mcfd_actl_t [mcfd_pkg::PIN_LAT-1:0] actlHist;
        logic [mcfd_pkg::FB_LAT-1:0] fbHist;
        logic [mcfd_pkg::FB_LAT-1:0] liveHist;
        logic isMaster;
        logic bufChkEn;
        logic [mcfd_pkg::DIS_W-1:0] dis;
        logic mbFlag;
        logic arrFlag;
        logic bufFlag;
        logic [mcfd_pkg::NUM_BUS-1:0] rptValid;
        mcfd_pkg::mcfd_rpt_t rptType;
        logic eccRpt;
        logic [mcfd_pkg::HOLD_CYCLES-1:0] holdPipe;
        logic commit;
    } mcfd_mcu_st_t;

    localparam mcfd_mcu_st_t ST_RST = '{
        actlOut: mcfd_pkg::ACTL_IDLE,
        s1: mcfd_pkg::PINS_RESET,
        s2: mcfd_pkg::PINS_RESET,
        actlHist: {mcfd_pkg::PIN_LAT{mcfd_pkg::ACTL_IDLE}},
        fbHist: '1,
        rptType: mcfd_pkg::RPT_NONE,
        default: '0
    };

    mcfd_mcu_st_t q;
    mcfd_mcu_st_t d;
    logic live;
    logic mbMis;
    logic adMis;
    logic ctlMis;
    logic arrMis;
    logic bufMis;
    logic anyErr;

    always_comb begin
        d = q;
        // Pin and feedback inputs pass two flops first
        d.s1 = link.pins;
        d.s2 = q.s1;
        d.roleS1 = link.rolePinLevel;
        d.roleS2 = q.roleS1;

        // Role and buffer check enable caught while init is high
        if (init) begin
            d.isMaster = q.roleS2;
            d.bufChkEn = bufChkStrap;
            d.dis = '0;
        end else if (swDisWr) begin
            d.dis = swDisVal;
        end

        // Only the master drives the bus, address and control lines; either role drives the role pin after init
        d.mbOut = '{data: mbDataInt, ctl: mbCtlInt, chk: mbChkInt};
        d.mbDrv = mbDrive & ~init;
        d.mbOe = mbDrive & q.isMaster & ~init;
        d.adOut = adInt;
        d.adDrv = adDrive & ~init;
        d.adOe = adDrive & q.isMaster & ~init;
        d.actlOut = '{rasN: rasIntN, deN: deIntN, weN: weIntN, refresh: refreshInt};
        d.actlOe = q.isMaster & ~init;
        d.bus_select_enable = {busActive, ~busActive};
        d.roleOe = ~init;

        // Own outputs delayed to line up with synchronised pins
        d.mbHist = {q.mbHist[mcfd_pkg::PIN_LAT-2:0], q.mbOut};
        d.mbDrvHist = {q.mbDrvHist[mcfd_pkg::PIN_LAT-2:0], q.mbDrv};
        d.adHist = {q.adHist[mcfd_pkg::PIN_LAT-2:0], q.adOut};
        d.adDrvHist = {q.adDrvHist[mcfd_pkg::PIN_LAT-2:0], q.adDrv};
        d.actlHist = {q.actlHist[mcfd_pkg::PIN_LAT-2:0], q.actlOut};
        d.fbHist = {q.fbHist[mcfd_pkg::FB_LAT-2:0], q.actlOut.rasN | q.actlOut.weN};
        d.liveHist = {q.liveHist[mcfd_pkg::FB_LAT-2:0], ~init};

        // Compare only once the pipes hold post-init values
        live = (&q.liveHist) & ~init;
        mbMis = live & ~q.isMaster & ~q.dis[mcfd_pkg::DIS_MB] & q.mbDrvHist[mcfd_pkg::PIN_LAT-1]
            & (|(q.s2.mb ^ q.mbHist[mcfd_pkg::PIN_LAT-1]));
        adMis = q.adDrvHist[mcfd_pkg::PIN_LAT-1]
            & (|(q.s2.ad ^ q.adHist[mcfd_pkg::PIN_LAT-1]));
        ctlMis = (|(q.s2.actl ^ q.actlHist[mcfd_pkg::PIN_LAT-1]))
            | (q.s2.feedback ^ q.fbHist[mcfd_pkg::FB_LAT-1]);
        arrMis = live & ~q.isMaster & ~q.dis[mcfd_pkg::DIS_ARR] & (adMis | ctlMis);
        // Evaluated regardless of role
        bufMis = live & q.bufChkEn & q.s2.bufErr;
        anyErr = mbMis | arrMis | bufMis;

        // Same report on every attached bus in the same cycle
        d.rptValid = {mcfd_pkg::NUM_BUS{anyErr}};
        if (arrMis) begin
            d.rptType = mcfd_pkg::RPT_UNSAFE;
        end else if (anyErr) begin
            d.rptType = mcfd_pkg::RPT_MODULE;
        end else begin
            d.rptType = mcfd_pkg::RPT_NONE;
        end

        // Sticky detection flags, set wins over clear
        d.mbFlag = mbMis | (q.mbFlag & ~flagClr);
        d.arrFlag = arrMis | (q.arrFlag & ~flagClr);
        d.bufFlag = bufMis | (q.bufFlag & ~flagClr);
        d.eccRpt = eccErr & ~q.dis[mcfd_pkg::DIS_ECC] & ~init;

        // Received data held until the error window has passed
        if (anyErr | (|q.rptValid)) begin
            d.holdPipe = '0;
            d.commit = 1'b0;
        end else begin
            d.holdPipe = {q.holdPipe[mcfd_pkg::HOLD_CYCLES-2:0], rxValid};
            d.commit = q.holdPipe[mcfd_pkg::HOLD_CYCLES-1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign link.mbOut = q.mbOut;
    assign link.mbOe = q.mbOe;
    assign link.adOut = q.adOut;
    assign link.adOe = q.adOe;
    assign link.actlOut = q.actlOut;
    assign link.actlOe = q.actlOe;
    assign link.bus_select_enable = q.bus_select_enable;
    assign link.rptValid = q.rptValid;
    assign link.rptType = q.rptType;
    assign link.devRoleOut = q.isMaster;
    assign link.devRoleOe = q.roleOe;
    assign isMaster = q.isMaster;
    assign disBits = q.dis;
    assign mbFrcFlag = q.mbFlag;
    assign arrFrcFlag = q.arrFlag;
    assign bufChkFlag = q.bufFlag;
    assign eccRptPulse = q.eccRpt;
    assign commitPulse = q.commit;
endmodule : mcfd_mcu_end

/* hw/mcfd_pkg.sv */
// Shared constants and types for the lockstep fault-detect ends
package mcfd_pkg;
    localparam int MB_DATA_W = 16;
    localparam int CTL_W = 3;
    localparam int CHK_W = 2;
    localparam int ARR_AD_W = 20;
    localparam int NUM_BUS = 2;
    // Cycles from own output register to synchronised pin copy
    localparam int PIN_LAT = 3;
    // Cycles from own output register to synchronised feedback copy
    localparam int FB_LAT = 4;
    localparam int HOLD_CYCLES = 3;
    localparam int DIS_W = 3;
    localparam int DIS_MB = 0;
    localparam int DIS_ARR = 1;
    localparam int DIS_ECC = 2;

    typedef enum logic [1:0] {
        RPT_NONE,
        RPT_MODULE,
        RPT_UNSAFE
    } mcfd_rpt_t;

    typedef struct packed {
        logic [MB_DATA_W-1:0] data;
        logic [CTL_W-1:0] ctl;
        logic [CHK_W-1:0] chk;
    } mcfd_mb_t;

    typedef struct packed {
        logic rasN;
        logic deN;
        logic weN;
        logic refresh;
    } mcfd_actl_t;

    localparam mcfd_actl_t ACTL_IDLE = '{rasN: 1'b1, deN: 1'b1, weN: 1'b1, refresh: 1'b0};

    // Line levels as seen at the board, returned to the unit
    typedef struct packed {
        mcfd_mb_t mb;
        logic [ARR_AD_W-1:0] ad;
        mcfd_actl_t actl;
        logic feedback;
        logic bufErr;
    } mcfd_pins_t;

    localparam mcfd_pins_t PINS_RESET = '{mb: '0, ad: '0, actl: ACTL_IDLE, feedback: 1'b1, bufErr: 1'b0};
endpackage : mcfd_pkg

/* hw/mcfd_if.sv */
// Link between the memory unit end and the external support logic end
interface mcfd_if;
    mcfd_pkg::mcfd_mb_t mbOut;
    logic mbOe;
    logic [mcfd_pkg::ARR_AD_W-1:0] adOut;
    logic adOe;
    mcfd_pkg::mcfd_actl_t actlOut;
    logic actlOe;
    logic [mcfd_pkg::NUM_BUS-1:0] bus_select_enable;
    logic [mcfd_pkg::NUM_BUS-1:0] rptValid;
    mcfd_pkg::mcfd_rpt_t rptType;
    logic devRoleOut;
    logic devRoleOe;
    mcfd_pkg::mcfd_pins_t pins;
    logic extRoleOut;
    logic extRoleOe;
    logic rolePinLevel;

    // Role pin wire level, pulled high when undriven
    assign rolePinLevel = devRoleOe ? devRoleOut : (extRoleOe ? extRoleOut : 1'b1);

    modport dev (
        output mbOut, mbOe, adOut, adOe, actlOut, actlOe, bus_select_enable, rptValid, rptType, devRoleOut, devRoleOe,
        input pins, rolePinLevel
    );
    modport ext (
        input mbOut, mbOe, adOut, adOe, actlOut, actlOe, bus_select_enable, rptValid, rptType, rolePinLevel,
        output pins, extRoleOut, extRoleOe
    );
endinterface : mcfd_if

/* hw/mcfd_ext_end.sv */
// External support logic end: strobes, feedback, buffer check, bus enables
module mcfd_ext_end (
    input wire logic ref_clk,
    input wire logic rst_n,
    mcfd_if.ext link,
    input wire logic [mcfd_pkg::MB_DATA_W-1:0] mbDataLine,
    input wire logic [mcfd_pkg::CTL_W-1:0] mbCtlLine,
    input wire logic [mcfd_pkg::CHK_W-1:0] mbChkLine,
    input wire logic [mcfd_pkg::ARR_AD_W-1:0] adLine,
    input wire logic rasLineN,
    input wire logic deLineN,
    input wire logic weLineN,
    input wire logic refreshLine,
    input wire logic [mcfd_pkg::NUM_BUS-1:0] loopActive,
    input wire logic [mcfd_pkg::NUM_BUS-1:0] peerBusSel,
    input wire logic initActive,
    input wire logic strapMaster,
    input wire logic rxValid,
    output logic casN,
    output logic [mcfd_pkg::NUM_BUS-1:0] bufEn,
    output logic holdOk
);
    typedef struct packed {
        mcfd_pkg::mcfd_pins_t pins;
        logic casN;
        logic [mcfd_pkg::NUM_BUS-1:0] bufEn;
        logic roleOut;
        logic roleOe;
        logic [mcfd_pkg::HOLD_CYCLES-1:0] holdPipe;
        logic holdOk;
    } mcfd_ext_st_t;

    localparam mcfd_ext_st_t ST_RST = '{pins: mcfd_pkg::PINS_RESET, casN: 1'b1, default: '0};

    mcfd_ext_st_t q;
    mcfd_ext_st_t d;

    always_comb begin
        d = q;
        d.pins.mb = '{data: mbDataLine, ctl: mbCtlLine, chk: mbChkLine};
        d.pins.ad = adLine;
        d.pins.actl = '{rasN: rasLineN, deN: deLineN, weN: weLineN, refresh: refreshLine};
        d.casN = rasLineN;
        d.pins.feedback = q.casN | q.pins.actl.weN;
        d.bufEn = link.bus_select_enable & peerBusSel;
        // Latched: active bus must loop back on, passive bus off
        d.pins.bufErr = |(loopActive ^ q.bufEn);
        d.roleOut = strapMaster;
        d.roleOe = initActive;
        if (|link.rptValid) begin
            d.holdPipe = '0;
            d.holdOk = 1'b0;
        end else begin
            d.holdPipe = {q.holdPipe[mcfd_pkg::HOLD_CYCLES-2:0], rxValid};
            d.holdOk = q.holdPipe[mcfd_pkg::HOLD_CYCLES-1];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign link.pins = q.pins;
    assign link.extRoleOut = q.roleOut;
    assign link.extRoleOe = q.roleOe;
    assign casN = q.casN;
    assign bufEn = q.bufEn;
    assign holdOk = q.holdOk;
endmodule : mcfd_ext_end

/* bench/mcfd_link_chk.sv */
// Assertions on the lockstep fault-detect link
module mcfd_link_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic mbOe,
    input wire logic adOe,
    input wire mcfd_pkg::mcfd_actl_t actlOut,
    input wire logic actlOe,
    input wire logic [1:0] bus_select_enable,
    input wire logic [1:0] rptValid,
    input wire mcfd_pkg::mcfd_rpt_t rptType,
    input wire logic devRoleOut,
    input wire logic devRoleOe,
    input wire mcfd_pkg::mcfd_pins_t pins,
    input wire logic extRoleOe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] armCnt_q;
    logic [3:0] armCnt_d;
    always_comb begin
        armCnt_d = armCnt_q;
        if (!devRoleOe)
            armCnt_d = 4'h0;
        else if (armCnt_q != 4'h8)
            armCnt_d = armCnt_q + 4'h1;
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            armCnt_q <= 4'h0;
        else
            armCnt_q <= armCnt_d;
    end
    sequence ctlMiss;
        armCnt_q == 4'h8 && !devRoleOut && pins.actl != $past(actlOut);
    endsequence
    sequence unsafeRpt;
        rptValid == 2'b11 && rptType == mcfd_pkg::RPT_UNSAFE;
    endsequence
    ctl_unsafe_a: assert property (ctlMiss |-> ##3 unsafeRpt) else $error("control mismatch unreported");
    rpt_both_a: assert property (rptValid != 2'b00 |-> rptValid == 2'b11) else $error("report on one bus");
    rpt_none_a: assert property (rptValid == 2'b00 |-> rptType == mcfd_pkg::RPT_NONE) else $error("stray type");
    rpt_typed_a: assert property (rptValid != 2'b00 |-> rptType != mcfd_pkg::RPT_NONE) else $error("untyped");
    master_safe_a: assert property (devRoleOe && devRoleOut |-> not unsafeRpt) else $error("master compared");
    checker_quiet_a: assert property (devRoleOe && !devRoleOut |-> !(mbOe || adOe || actlOe))
        else $error("checker drives lines");
    bus_onehot_a: assert property (devRoleOe |-> $onehot(bus_select_enable)) else $error("bus select not one-hot");
    role_clash_a: assert property (!(devRoleOe && extRoleOe)) else $error("role pin contention");
    reset_idle_a: assert property ($rose(rst_n) |-> !(mbOe || adOe || actlOe) && pins.feedback && !pins.bufErr)
        else $error("not idle after reset");
endmodule : mcfd_link_chk

/* bench/tb_memory_ctrl_lockstep_fault_detect.sv */
// Self-checking bench for the lockstep fault-detect link
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_memory_ctrl_lockstep_fault_detect;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, rst_n = 1'b0, init = 1'b1, mbDrive = 1'b0, adDrive = 1'b0, busActive = 1'b1;
    logic swDisWr = 1'b0, flagClr = 1'b0, eccErr = 1'b0, rxValid = 1'b0, strapMaster = 1'b0;
    logic [2:0] swDisVal = 3'h0;
    logic [3:0] ctlInt = 4'he, ctlFlip = 4'h0;
    logic [15:0] mbData = 16'ha5c3, mbFlip = 16'h0;
    logic [19:0] adData = 20'h5a3c1, adFlip = 20'h0;
    logic [1:0] bufFlip = 2'h0, peerFlip = 2'h0, bufEn;
    logic [2:0] disBits;
    logic isMaster, mbFrcFlag, arrFrcFlag, bufChkFlag, eccRptPulse, commitPulse, casN, holdOk;
    int mismatches = 0, checks = 0, pos;
    mcfd_pkg::mcfd_rpt_t got;
    mcfd_if mcfd_if_inst ();
    always #2 ref_clk = ~ref_clk;
    mcfd_mcu_end mcfd_mcu_end_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(mcfd_if_inst.dev), .init(init),
        .mbDataInt(mbData), .mbCtlInt(3'h5), .mbChkInt(2'h2), .mbDrive(mbDrive), .adInt(adData),
        .adDrive(adDrive), .rasIntN(ctlInt[3]), .deIntN(ctlInt[2]), .weIntN(ctlInt[1]), .refreshInt(ctlInt[0]),
        .busActive(busActive), .bufChkStrap(1'b1), .swDisWr(swDisWr), .swDisVal(swDisVal), .flagClr(flagClr),
        .eccErr(eccErr), .rxValid(rxValid), .isMaster(isMaster), .disBits(disBits), .mbFrcFlag(mbFrcFlag),
        .arrFrcFlag(arrFrcFlag), .bufChkFlag(bufChkFlag), .eccRptPulse(eccRptPulse), .commitPulse(commitPulse));
    mcfd_ext_end mcfd_ext_end_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(mcfd_if_inst.ext),
        .mbDataLine(mcfd_if_inst.mbOut.data ^ mbFlip), .mbCtlLine(mcfd_if_inst.mbOut.ctl),
        .mbChkLine(mcfd_if_inst.mbOut.chk), .adLine(mcfd_if_inst.adOut ^ adFlip),
        .rasLineN(mcfd_if_inst.actlOut.rasN ^ ctlFlip[3]), .deLineN(mcfd_if_inst.actlOut.deN ^ ctlFlip[2]),
        .weLineN(mcfd_if_inst.actlOut.weN ^ ctlFlip[1]), .refreshLine(mcfd_if_inst.actlOut.refresh ^ ctlFlip[0]),
        .loopActive(bufEn ^ bufFlip), .peerBusSel(mcfd_if_inst.bus_select_enable ^ peerFlip), .initActive(init),
        .strapMaster(strapMaster),
        .rxValid(rxValid), .casN(casN), .bufEn(bufEn), .holdOk(holdOk));
    mcfd_link_chk mcfd_link_chk_inst (.ref_clk(ref_clk), .rst_n(rst_n), .mbOe(mcfd_if_inst.mbOe),
        .adOe(mcfd_if_inst.adOe), .actlOut(mcfd_if_inst.actlOut), .actlOe(mcfd_if_inst.actlOe),
        .bus_select_enable(mcfd_if_inst.bus_select_enable), .rptValid(mcfd_if_inst.rptValid), .rptType(mcfd_if_inst.rptType),
        .devRoleOut(mcfd_if_inst.devRoleOut), .devRoleOe(mcfd_if_inst.devRoleOe), .pins(mcfd_if_inst.pins),
        .extRoleOe(mcfd_if_inst.extRoleOe));
    task step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task prep;
        flagClr = 1'b1;
        step(1);
        flagClr = 1'b0;
        step(6);
    endtask : prep
    // One-cycle line disturbance, then the report seen within eight cycles
    task poke(input logic [15:0] m, input logic [19:0] a, input logic [3:0] c, input logic [1:0] b);
        {mbFlip, adFlip, ctlFlip, bufFlip} = {m, a, c, b};
        step(1);
        {mbFlip, adFlip, ctlFlip, bufFlip} = '0;
        got = mcfd_pkg::RPT_NONE;
        repeat (8) begin
            step(1);
            if (mcfd_if_inst.rptValid !== 2'b00)
                got = mcfd_if_inst.rptType;
        end
    endtask : poke
    task t_mb;
        mbDrive = 1'b1;
        prep;
        poke(16'h0100, 20'h0, 4'h0, 2'h0);
        `CHK(got, mcfd_pkg::RPT_MODULE)
        `CHK(mbFrcFlag, 1'b1)
        mbDrive = 1'b0;
        prep;
        poke(16'h0100, 20'h0, 4'h0, 2'h0);
        `CHK(got, mcfd_pkg::RPT_NONE)
    endtask : t_mb
    task t_arr;
        adDrive = 1'b1;
        prep;
        poke(16'h0, 20'h80000, 4'h0, 2'h0);
        `CHK(got, mcfd_pkg::RPT_UNSAFE)
        `CHK(arrFrcFlag, 1'b1)
        adDrive = 1'b0;
        prep;
        poke(16'h0, 20'h80000, 4'h0, 2'h0);
        `CHK(got, mcfd_pkg::RPT_NONE)
    endtask : t_arr
    task t_ctl;
        for (int i = 0; i < 4; i++) begin
            prep;
            poke(16'h0, 20'h0, 4'h1 << i, 2'h0);
            `CHK(got, mcfd_pkg::RPT_UNSAFE)
        end
        // Row strobe and write enable low: column strobe and feedback follow
        ctlInt = 4'h4;
        step(3);
        `CHK(casN, 1'b0)
        `CHK(mcfd_if_inst.pins.feedback, 1'b0)
        prep;
        poke(16'h0, 20'h0, 4'h0, 2'h0);
        `CHK(got, mcfd_pkg::RPT_NONE)
        ctlInt = 4'he;
        step(3);
    endtask : t_ctl
    task t_dis;
        {swDisVal, swDisWr, mbDrive} = {3'h5, 1'b1, 1'b1};
        step(1);
        swDisWr = 1'b0;
        step(1);
        `CHK(disBits, 3'h5)
        eccErr = 1'b1;
        step(1);
        eccErr = 1'b0;
        `CHK(eccRptPulse, 1'b0)
        prep;
        poke(16'h0001, 20'h0, 4'h0, 2'h0);
        `CHK(got, mcfd_pkg::RPT_NONE)
        {swDisVal, swDisWr} = {3'h0, 1'b1};
        step(1);
        swDisWr = 1'b0;
    endtask : t_dis
    task t_buf;
        prep;
        `CHK(bufEn, 2'b10)
        poke(16'h0, 20'h0, 4'h0, 2'b01);
        `CHK(got, mcfd_pkg::RPT_MODULE)
        `CHK(bufChkFlag, 1'b1)
        busActive = 1'b0;
        step(3);
        `CHK(bufEn, 2'b01)
        // Partner disagrees: ANDed enable drops both buses
        peerFlip = 2'b01;
        step(2);
        `CHK(bufEn, 2'b00)
        peerFlip = 2'b00;
        step(2);
    endtask : t_buf
    task t_ecc_hold;
        eccErr = 1'b1;
        step(1);
        eccErr = 1'b0;
        `CHK(eccRptPulse, 1'b1)
        rxValid = 1'b1;
        step(1);
        rxValid = 1'b0;
        pos = 0;
        for (int k = 1; k < 7; k++) begin
            step(1);
            if (commitPulse === 1'b1 && holdOk === 1'b1)
                pos = k;
        end
        `CHK(pos, 3)
        ctlFlip = 4'h2;
        step(1);
        {ctlFlip, rxValid} = {4'h0, 1'b1};
        step(1);
        rxValid = 1'b0;
        pos = 0;
        for (int k = 1; k < 7; k++) begin
            step(1);
            if (commitPulse !== 1'b0 || holdOk !== 1'b0)
                pos = k;
        end
        `CHK(pos, 0)
    endtask : t_ecc_hold
    // Mid-run reset into master role: no lockstep compare, buffer check still live
    task t_master;
        {rst_n, init, strapMaster} = {1'b0, 1'b1, 1'b1};
        step(2);
        rst_n = 1'b1;
        step(8);
        init = 1'b0;
        step(8);
        `CHK(isMaster, 1'b1)
        `CHK(mcfd_if_inst.devRoleOut, 1'b1)
        `CHK(mcfd_if_inst.mbOe, 1'b1)
        prep;
        poke(16'h0100, 20'h80000, 4'h1, 2'h0);
        `CHK(got, mcfd_pkg::RPT_NONE)
        prep;
        poke(16'h0, 20'h0, 4'h0, 2'b01);
        `CHK(got, mcfd_pkg::RPT_MODULE)
        `CHK(bufChkFlag, 1'b1)
    endtask : t_master
    task end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    initial begin
        step(16);
        rst_n = 1'b1;
        step(8);
        init = 1'b0;
        step(8);
        `CHK(isMaster, 1'b0)
        t_mb;
        t_arr;
        t_ctl;
        t_dis;
        t_buf;
        t_ecc_hold;
        t_master;
        end_sim;
    end
    initial begin
        #20000;
        mismatches++;
        end_sim;
    end
endmodule : tb_memory_ctrl_lockstep_fault_detect
